// [design/gpio_port_pkg.sv]
/*
  Constants for the general digital I/O port: APB register offsets,
  field positions, reset values and synchroniser timing.
  Assumes a 32-bit APB with word-aligned registers.
*/
package gpio_port_pkg;
  localparam int PinCount = 8;
  // Register byte offsets
  localparam logic [11:0] InputRegOff = 12'h000;
  localparam logic [11:0] DirectionRegOff = 12'h004;
  localparam logic [11:0] OutputRegOff = 12'h008;
  localparam logic [11:0] McuControlRegOff = 12'h00c;
  localparam logic [11:0] SleepRegOff = 12'h010;
  localparam logic [11:0] ExtIntRegOff = 12'h014;
  localparam logic [11:0] ExtFlagRegOff = 12'h018;
  // Field positions
  localparam int PullupDisableBit = 4;
  localparam int SleepClampBit = 0;
  // Reset values
  localparam logic [7:0] DirectionReset = 8'h00;
  localparam logic [7:0] OutputReset = 8'h00;
  localparam logic [7:0] ByteZero = 8'h00;
  // Synchroniser delay for a software-written level
  localparam int ClockPeriodNs = 10;
  localparam int SoftwareEchoNs = 10;
  localparam int SoftwareEchoCycles = SoftwareEchoNs / ClockPeriodNs;
endpackage

// [design/input_sync.sv]
/*
  Latch-plus-flop input synchroniser for one port.
  Assumes clk is the port clock; pad levels are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module input_sync
#(
  parameter int Width = 8
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [Width-1:0] padLevel,
  output logic [Width-1:0] sample
);
  logic [Width-1:0] latchQ;

  // Transparent while clk high, holds from the falling edge
  always_latch
  begin
    if (clk)
    begin
      latchQ = padLevel;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sample <= '0;
    end
    else
    begin
      sample <= latchQ;
    end
  end
endmodule
`default_nettype wire

// [design/general_digital_io_port.sv]
/*
  General digital I/O port: eight pins with direction, output value,
  pull-up control, toggle-by-write, synchronised input, sleep clamp and
  external-interrupt resume flags. APB slave for the registers.
  Assumes pads resolve padOut/padOe/pullupEn outside; sleepActive
  comes from the sleep controller on this clock.
*/
`timescale 1ns/1ps
`default_nettype none
module general_digital_io_port
  import gpio_port_pkg::*;
#(
  parameter int Width = PinCount
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepActive,
  input wire logic [Width-1:0] padIn,
  output logic [Width-1:0] padOut,
  output logic [Width-1:0] padOe,
  output logic [Width-1:0] pullupEn,
  output logic [Width-1:0] extIntFlag
);
  logic [Width-1:0] portDirectionReg;
  logic [Width-1:0] portOutputReg;
  logic globalPullupDisableReg;
  logic [Width-1:0] extIntEnableReg;
  logic [Width-1:0] extIntEdgeModeReg;
  logic [Width-1:0] extIntFlagReg;
  logic [Width-1:0] extIntFlagNext;
  logic sleepClampReg;
  logic [Width-1:0] padMeta;
  logic [Width-1:0] padSync;
  logic [Width-1:0] clampedLevel;
  logic [Width-1:0] portInputSample;
  logic [31:0] readData;
  logic access;
  logic writeAccess;
  logic mapped;

  function automatic logic [31:0] widen(input logic [Width-1:0] v);
    widen = 32'h0000_0000;
    widen[Width-1:0] = v;
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign access = psel && penable;
  assign writeAccess = access && pwrite;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // padOe and pullupEn are gated by nrst so reset acts without a clock; padOut clears on a clock edge
  assign padOe = nrst ? portDirectionReg : '0;
  assign padOut = portOutputReg;
  assign pullupEn = (nrst && !globalPullupDisableReg)
    ? (~portDirectionReg & portOutputReg) : '0;

  // Clamp sits ahead of the synchroniser, like the input buffer
  assign clampedLevel = (sleepActive || sleepClampReg)
    ? (padIn & extIntEnableReg) : padIn;

  input_sync #(.Width(Width)) inputSync
  (
    .clk(clk),
    .nrst(nrst),
    .padLevel(clampedLevel),
    .sample(portInputSample)
  );

  // Separate two-flop path for interrupt flags, level only
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      padMeta <= '0;
      padSync <= '0;
    end
    else
    begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      portDirectionReg <= DirectionReset[Width-1:0];
    end
    else if (writeAccess && hit(paddr, DirectionRegOff))
    begin
      portDirectionReg <= pwdata[Width-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      portOutputReg <= OutputReset[Width-1:0];
    end
    else if (writeAccess && hit(paddr, OutputRegOff))
    begin
      portOutputReg <= pwdata[Width-1:0];
    end
    else if (writeAccess && hit(paddr, InputRegOff))
    begin
      portOutputReg <= portOutputReg ^ pwdata[Width-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      globalPullupDisableReg <= 1'b0;
      sleepClampReg <= 1'b0;
      extIntEnableReg <= '0;
      extIntEdgeModeReg <= '0;
    end
    else if (writeAccess)
    begin
      if (hit(paddr, McuControlRegOff))
      begin
        globalPullupDisableReg <= pwdata[PullupDisableBit];
      end
      if (hit(paddr, SleepRegOff))
      begin
        sleepClampReg <= pwdata[SleepClampBit];
      end
      if (hit(paddr, ExtIntRegOff))
      begin
        extIntEnableReg <= pwdata[Width-1:0];
        extIntEdgeModeReg <= pwdata[Width+7:8];
      end
    end
  end

  // Wake flag: clamp forced a low, a high pin is the requested change
  logic wasClamped;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wasClamped <= 1'b0;
    end
    else
    begin
      wasClamped <= sleepActive || sleepClampReg;
    end
  end

  always_comb
  begin
    extIntFlagNext = extIntFlagReg;
    if (writeAccess && hit(paddr, ExtFlagRegOff))
    begin
      extIntFlagNext = extIntFlagReg & ~pwdata[Width-1:0];
    end
    // Set wins over a same-cycle clear
    if (wasClamped && !(sleepActive || sleepClampReg))
    begin
      extIntFlagNext = extIntFlagNext
        | (padSync & extIntEdgeModeReg & ~extIntEnableReg);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      extIntFlagReg <= '0;
    end
    else
    begin
      extIntFlagReg <= extIntFlagNext;
    end
  end

  assign extIntFlag = extIntFlagReg;

  always_comb
  begin
    mapped = 1'b1;
    readData = 32'h0000_0000;
    case (paddr)
      InputRegOff: readData = widen(portInputSample);
      DirectionRegOff: readData = widen(portDirectionReg);
      OutputRegOff: readData = widen(portOutputReg);
      McuControlRegOff: readData[PullupDisableBit] = globalPullupDisableReg;
      SleepRegOff: readData[SleepClampBit] = sleepClampReg;
      ExtIntRegOff:
      begin
        readData[Width-1:0] = extIntEnableReg;
        readData[Width+7:8] = extIntEdgeModeReg;
      end
      ExtFlagRegOff: readData = widen(extIntFlagReg);
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= readData;
    end
  end
endmodule
`default_nettype wire

// [bench/pad_model.sv]
/*
  Pad model: resolves the port drive against an external source.
  Assumes the bench drives a pin only while the port does not.
*/
`timescale 1ns/1ps
`default_nettype none
module pad_model
(
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] pullupEn,
  input wire logic [7:0] extEn,
  input wire logic [7:0] extVal,
  output logic [7:0] padLevel
);
  // Floating pins read high when pulled up, else the inverse of padOut, never a held value
  assign padLevel = (padOe & padOut) | (~padOe & extEn & extVal)
    | (~padOe & ~extEn & (pullupEn | ~padOut));
endmodule
`default_nettype wire

// [bench/general_digital_io_port_chk.sv]
/*
  Assertions on the port pins against APB writes.
  Assumes zero-wait APB; bound to the port's top module.
*/
`timescale 1ns/1ps
`default_nettype none
module general_digital_io_port_chk
  import gpio_port_pkg::*;
#(
  parameter int Width = PinCount
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [Width-1:0] padOut,
  input wire logic [Width-1:0] padOe,
  input wire logic [Width-1:0] pullupEn
);
  logic wr;
  assign wr = psel && penable && pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  rst_clear_a: assert property ($rose(nrst) |-> padOe == '0 && pullupEn == '0)
    else $error("pins not idle after reset");
  dir_write_a: assert property (wr && paddr == DirectionRegOff |=>
    padOe == $past(pwdata[Width-1:0])) else $error("enable not from direction");
  drive_level_a: assert property (wr && paddr == OutputRegOff |=>
    padOut == $past(pwdata[Width-1:0])) else $error("drive not from value");
  toggle_write_a: assert property (wr && paddr == InputRegOff |=>
    padOut == ($past(padOut) ^ $past(pwdata[Width-1:0]))) else $error("bad toggle");
  pull_on_a: assert property (wr && paddr == McuControlRegOff && !pwdata[PullupDisableBit]
    |=> pullupEn == (~padOe & padOut)) else $error("pull-up not on");
  pull_gone_a: assert property (wr && paddr == McuControlRegOff && pwdata[PullupDisableBit]
    |=> (pullupEn == '0) [*2]) else $error("pull-up not off");
  pull_off_a: assert property ((pullupEn & (padOe | ~padOut)) == '0)
    else $error("stray pull-up");
endmodule
bind general_digital_io_port general_digital_io_port_chk #(.Width(Width)) u_chk (.clk, .nrst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .padOut, .padOe, .pullupEn);
`default_nettype wire

// [bench/testbench.sv]
/*
  Self-checking bench for the I/O port over APB.
  Assumes zero-wait APB and a pad model on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import gpio_port_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic sleepActive = 1'b0;
  logic [7:0] extEn = '0;
  logic [7:0] extVal = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] padIn;
  logic [7:0] padOut;
  logic [7:0] padOe;
  logic [7:0] pullupEn;
  logic [7:0] extIntFlag;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  general_digital_io_port u_general_digital_io_port (.clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sleepActive, .padIn, .padOut, .padOe,
    .pullupEn, .extIntFlag);
  pad_model u_pad_model (.padOut, .padOe, .pullupEn, .extEn, .extVal, .padLevel(padIn));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [7:0] h = 8'h00);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, h, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fails++;
      conclude();
    end
  endtask
  task automatic rstT();
    apb(1'b1, DirectionRegOff, 8'h0f);
    apb(1'b1, OutputRegOff, 8'hf0);
    @(posedge clk);
    nrst <= 1'b0;
    #1;
    check(padOe, 8'h00);
    check(pullupEn, 8'h00);
    @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, DirectionRegOff, 8'h00);
    check(rd, 32'h0);
    apb(1'b0, OutputRegOff, 8'h00);
    check(rd, 32'h0);
  endtask
  task automatic cfgT();
    logic [11:0] a [4] = '{OutputRegOff, DirectionRegOff, OutputRegOff, DirectionRegOff};
    logic [7:0] d [4] = '{8'hff, 8'hff, 8'h00, 8'h00};
    logic [7:0] dir = 8'h00;
    logic [7:0] val = 8'h00;
    // One bit pair per step, so no forbidden jump
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, a[i], d[i]);
      if (a[i] == DirectionRegOff)
        dir = d[i];
      else
        val = d[i];
      @(posedge clk);
      check(padOe, dir);
      check(padOut & dir, val & dir);
      check(pullupEn, ~dir & val);
    end
  endtask
  task automatic pudT();
    apb(1'b1, OutputRegOff, 8'hff);
    apb(1'b1, McuControlRegOff, 8'h10);
    @(posedge clk);
    check(pullupEn, 8'h00);
    apb(1'b1, McuControlRegOff, 8'h00);
    repeat (2) @(posedge clk);
    apb(1'b0, InputRegOff, 8'h00);
    check(rd, 32'hff);
  endtask
  task automatic togT();
    apb(1'b1, OutputRegOff, 8'h3c);
    apb(1'b1, InputRegOff, 8'h0f);
    apb(1'b1, InputRegOff, 8'h00);
    apb(1'b0, OutputRegOff, 8'h00);
    check(rd, 32'h33);
    apb(1'b1, DirectionRegOff, 8'hff);
    @(posedge clk);
    apb(1'b0, InputRegOff, 8'h00);
    check(rd, 32'h33);
    apb(1'b1, DirectionRegOff, 8'h00);
    apb(1'b1, OutputRegOff, 8'h00);
  endtask
  task automatic slpT();
    extEn <= 8'hff;
    extVal <= 8'ha5;
    repeat (2) @(posedge clk);
    apb(1'b0, InputRegOff, 8'h00);
    check(rd, 32'ha5);
    // Pin 0 enabled, pins 7..1 in edge mode but disabled
    apb(1'b1, ExtIntRegOff, 8'h01, 8'hfe);
    extVal <= 8'hff;
    sleepActive <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, InputRegOff, 8'h00);
    check(rd, 32'h01);
    sleepActive <= 1'b0;
    repeat (2) @(posedge clk);
    check(extIntFlag, 8'hfe);
    apb(1'b1, ExtFlagRegOff, 8'hfe);
    @(posedge clk);
    check(extIntFlag, 8'h00);
    // Software clamp bit takes the same path as the sleep controller
    apb(1'b1, SleepRegOff, 8'h01);
    repeat (3) @(posedge clk);
    apb(1'b0, InputRegOff, 8'h00);
    check(rd, 32'h01);
    apb(1'b1, SleepRegOff, 8'h00);
    repeat (2) @(posedge clk);
    check(extIntFlag, 8'hfe);
    apb(1'b0, 12'h01c, 8'h00);
    check(err, 1'b1);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rstT();
    cfgT();
    pudT();
    togT();
    slpT();
    conclude();
  end
endmodule
`default_nettype wire
